// ---- logic/cmi_pkg.sv ----
// shared constants and state types for the coded-mark-inversion coder/decoder
package cmi_pkg;

  // ==========================================================
  // line symbol pairs, first symbol in bit 1
  localparam logic [1:0] SYM_ZERO    = 2'h1;
  localparam logic [1:0] SYM_ONE_LOW = 2'h0;
  localparam logic [1:0] SYM_ONE_HIGH = 2'h3;

  // ==========================================================
  // latencies in enable cycles of the 2x clock
  localparam int CODER_LAT    = 3;
  localparam int DECODER_LAT  = 4;
  localparam int LOOP_LAT     = 5;

  // ==========================================================
  // buffer geometry and reset values
  localparam int   FIFO_DEPTH   = 2;
  localparam int   FIFO_AW      = 1;
  localparam logic RST_BIT      = 1'b0;
  localparam logic RST_ALT      = 1'b0;
  localparam logic RST_PHASE    = 1'b0;

  typedef struct packed {
    logic [FIFO_DEPTH-1:0] mem;
    logic [FIFO_AW-1:0]    wr;
    logic [FIFO_AW-1:0]    rd;
    logic [FIFO_AW:0]      cnt;
    logic                  full;
  } cmi_fifo_st_t;

  typedef struct packed {
    logic cap;
    logic prev;
    logic ph;
    logic bit_q;
    logic bv;
    logic d3;
  } cmi_dec_st_t;

  typedef struct packed {
    logic [1:0] binary_loopback_select_sync;
    logic [1:0] coded_loopback_select_sync;
    logic       c_ph;
    logic       in_bit;
    logic       in_stb;
    logic [2:0] lb;
    logic [1:0] pair;
    logic       pair_v;
    logic [1:0] sh;
    logic       sel;
    logic       alt;
    logic       sym;
    logic       decoded_binary_out;
    logic       dclk;
  } cmi_top_st_t;

endpackage

// ---- logic/cmi_if.sv ----
// carriers between the top and its buffer and decoder
`timescale 1ns/10ps
`default_nettype none

interface cmi_bit_if;
  logic data;
  logic valid;
  logic ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface

interface cmi_dec_if;
  logic bit_q;
  logic stb;
  logic late_bit;
  logic half_clk;
  modport prod (output bit_q, output stb, output late_bit, output half_clk);
  modport cons (input bit_q, input stb, input late_bit, input half_clk);
endinterface

`default_nettype wire

// ---- logic/cmi_fifo2.sv ----
// two-entry buffer for binary input bits
`timescale 1ns/10ps
`default_nettype none

module cmi_fifo2 (
  // clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_rst_n,
  // filling side
  input  wire logic i_data,
  input  wire logic i_valid,
  output logic      o_ready,
  // draining side
  cmi_bit_if.src    drain
);

  cmi_pkg::cmi_fifo_st_t s_ff;
  cmi_pkg::cmi_fifo_st_t nxt_s;
  logic                  push;
  logic                  pop;

  always_comb begin
    nxt_s = s_ff;
    push  = i_valid && !s_ff.full;
    pop   = drain.ready && (s_ff.cnt != '0);
    if (push) begin
      nxt_s.mem[s_ff.wr] = i_data;
      nxt_s.wr = s_ff.wr + 1'b1;
    end
    if (pop) begin
      nxt_s.rd = s_ff.rd + 1'b1;
    end
    nxt_s.cnt  = s_ff.cnt + {1'b0, push} - {1'b0, pop};
    nxt_s.full = (nxt_s.cnt == 2'(cmi_pkg::FIFO_DEPTH));
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign o_ready     = !s_ff.full;
  assign drain.valid = (s_ff.cnt != '0);
  assign drain.data  = s_ff.mem[s_ff.rd];

  // ==========================================================
  // checks
  property p_fifo_no_overflow;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      s_ff.full |-> (s_ff.cnt == 2'(cmi_pkg::FIFO_DEPTH)) && !o_ready;
  endproperty
  a_fifo_no_overflow: assert property (p_fifo_no_overflow) else $error("buffer full flag wrong");

endmodule

`default_nettype wire

// ---- logic/cmi_decoder.sv ----
// coded line decoder with pair alignment
`timescale 1ns/10ps
`default_nettype none

module cmi_decoder (
  // clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_rst_n,
  // line side
  input  wire logic i_dce,
  input  wire logic i_coded_line_in,
  // decoded stream
  cmi_dec_if.prod   dec
);

  cmi_pkg::cmi_dec_st_t s_ff;
  cmi_pkg::cmi_dec_st_t nxt_s;
  logic                 bad_pair;

  always_comb begin
    nxt_s    = s_ff;
    bad_pair = s_ff.prev && !s_ff.cap;
    if (i_dce) begin
      nxt_s.prev = s_ff.cap;
      nxt_s.cap  = i_coded_line_in;
      nxt_s.bv   = 1'b0;
      nxt_s.d3   = s_ff.bit_q;
      if (s_ff.ph) begin
        nxt_s.bit_q = (s_ff.prev == s_ff.cap); // RULE_18
        nxt_s.bv    = !bad_pair; // RULE_18
      end
      // a high-low pair cannot start a bit: slip one symbol, no strobe
      // so a re-coder downstream never sees two strobes back to back
      nxt_s.ph = (s_ff.ph && bad_pair) ? 1'b1 : !s_ff.ph; // RULE_18
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      s_ff <= '0; // RULE_19
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign dec.bit_q    = s_ff.bit_q;
  assign dec.stb      = s_ff.bv;
  assign dec.late_bit = s_ff.d3;
  assign dec.half_clk = s_ff.ph;

  // ==========================================================
  // checks
  property p_dec_value;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      (i_dce && s_ff.ph) |=> (s_ff.bit_q == ($past(s_ff.prev) == $past(s_ff.cap)));
  endproperty
  a_dec_value: assert property (p_dec_value) else $error("decoded bit wrong"); // RULE_18

  property p_dec_slip;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      (i_dce && s_ff.ph && s_ff.prev && !s_ff.cap) |=> !s_ff.bv && s_ff.ph;
  endproperty
  a_dec_slip: assert property (p_dec_slip) else $error("decoder did not slip on high-low pair"); // RULE_18

  property p_dec_stage;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      i_dce |=> (s_ff.d3 == $past(s_ff.bit_q));
  endproperty
  a_dec_stage: assert property (p_dec_stage) else $error("decoder delay stage wrong"); // RULE_09

endmodule

`default_nettype wire

// ---- logic/cmi_codec.sv ----
// top: coder, loopback routing and alarm pattern
// How it works
// [RULE_01] each binary bit becomes two consecutive line symbols
// [RULE_02] a zero is sent as low then high
// [RULE_03] ones alternate between both-low and both-high, zeros in between ignored
// [RULE_04] each line symbol lasts one coder clock enable period
// [RULE_05] system supplies coder clock at twice the data rate
// [RULE_06] coder clock is halved and driven out as bit-rate clock
// [RULE_07] coded output follows the binary bit by three coder clocks
// [RULE_08] recovered decoder clock runs at the coded line rate
// [RULE_09] decoded bit appears four decoder clocks after capture
// [RULE_10] two select inputs steer routing between coder and decoder
// [RULE_11] binary loopback routes binary input and halved coder clock to decoder outputs
// [RULE_12] binary loopback latency is three coder clocks
// [RULE_13] binary loopback sends the alarm pattern on the line
// [RULE_14] alarm pattern is alternating ones, read as constant high
// [RULE_15] coded loopback decodes line input and re-encodes it to line output
// [RULE_16] coded loopback latency is five decoder clocks
// [RULE_17] system should assert reset during power-up
// [RULE_18] decoder outputs zero for split pairs, one for equal pairs, aligned
// [RULE_19] reset clears pipelines, dividers and the ones alternation
`timescale 1ns/10ps
`default_nettype none

module cmi_codec (
  // clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_rst_n,
  // coder side
  input  wire logic i_coder_clock_in,
  input  wire logic i_binary_data_in,
  input  wire logic i_binary_valid,
  output logic      o_binary_ready,
  output logic      o_coded_line_out,
  output logic      o_coder_clock_out,
  // decoder side
  input  wire logic i_decoder_clock_in,
  input  wire logic i_coded_line_in,
  output logic      o_decoded_binary_out,
  output logic      o_decoder_clock_out,
  // loopback control pins
  input  wire logic i_binary_loopback_select,
  input  wire logic i_coded_loopback_select
);

  cmi_pkg::cmi_top_st_t s_ff;
  cmi_pkg::cmi_top_st_t nxt_s;
  cmi_bit_if            bin_q ();
  cmi_dec_if            dec ();
  logic                 binary_loopback_select;
  logic                 coded_loopback_select;
  logic                 ce;
  logic                 src_stb;
  logic                 src_bit;
  logic                 bin_bit;
  logic                 fifo_ready_q;

  function automatic logic [1:0] encode(input logic b, input logic alt);
    if (!b) begin
      return cmi_pkg::SYM_ZERO;
    end
    return alt ? cmi_pkg::SYM_ONE_HIGH : cmi_pkg::SYM_ONE_LOW;
  endfunction

  // ==========================================================
  // input buffer and decoder
  cmi_fifo2 u_fifo (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_data    (i_binary_data_in),
    .i_valid   (i_binary_valid),
    .o_ready   (fifo_ready_q),
    .drain     (bin_q.src)
  );

  cmi_decoder u_dec (
    .i_ref_clk       (i_ref_clk),
    .i_rst_n         (i_rst_n),
    .i_dce           (i_decoder_clock_in),
    .i_coded_line_in (i_coded_line_in),
    .dec             (dec.prod)
  );

  // ==========================================================
  // routing and coder
  assign binary_loopback_select = s_ff.binary_loopback_select_sync[1];
  assign coded_loopback_select = s_ff.coded_loopback_select_sync[1];
  assign ce   = coded_loopback_select ? i_decoder_clock_in : i_coder_clock_in; // RULE_10 RULE_15
  assign bin_q.ready = i_coder_clock_in && !s_ff.c_ph && !coded_loopback_select;
  assign bin_bit = bin_q.valid ? bin_q.data : 1'b1;
  assign src_stb = coded_loopback_select ? dec.stb : s_ff.in_stb; // RULE_15
  assign src_bit = coded_loopback_select ? dec.bit_q : s_ff.in_bit;

  always_comb begin
    nxt_s = s_ff;
    nxt_s.binary_loopback_select_sync = {s_ff.binary_loopback_select_sync[0], i_binary_loopback_select};
    nxt_s.coded_loopback_select_sync = {s_ff.coded_loopback_select_sync[0], i_coded_loopback_select};
    if (i_coder_clock_in) begin
      nxt_s.c_ph = !s_ff.c_ph; // RULE_06
      nxt_s.lb   = {s_ff.lb[1:0], s_ff.lb[0]};
      if (!s_ff.c_ph) begin
        nxt_s.in_bit = binary_loopback_select ? 1'b1 : bin_bit; // RULE_13 RULE_14
        nxt_s.in_stb = 1'b1;
        nxt_s.lb[0]  = bin_bit; // RULE_11
      end else begin
        nxt_s.in_stb = 1'b0;
      end
    end
    if (ce) begin
      nxt_s.pair_v = 1'b0;
      if (src_stb) begin
        nxt_s.pair   = encode(src_bit, s_ff.alt); // RULE_01 RULE_02 RULE_03
        nxt_s.pair_v = 1'b1;
        if (src_bit) begin
          nxt_s.alt = !s_ff.alt; // RULE_03
        end
      end
      nxt_s.sym = s_ff.sel ? s_ff.sh[1] : s_ff.sh[0]; // RULE_04 RULE_07 RULE_16
      nxt_s.sel = 1'b0;
      if (s_ff.pair_v) begin
        nxt_s.sh  = s_ff.pair;
        nxt_s.sel = 1'b1;
      end
    end
    if (binary_loopback_select) begin
      if (i_coder_clock_in) begin
        nxt_s.decoded_binary_out = s_ff.lb[2]; // RULE_11 RULE_12
      end
    end else if (i_decoder_clock_in) begin
      nxt_s.decoded_binary_out = dec.late_bit; // RULE_09
    end
    nxt_s.dclk = binary_loopback_select ? s_ff.c_ph : dec.half_clk; // RULE_11
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      s_ff        <= '0; // RULE_19
      s_ff.alt    <= cmi_pkg::RST_ALT;
      s_ff.c_ph   <= cmi_pkg::RST_PHASE;
      s_ff.in_bit <= cmi_pkg::RST_BIT;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ==========================================================
  // outputs
  assign o_binary_ready       = fifo_ready_q;
  assign o_coded_line_out     = s_ff.sym;
  assign o_coder_clock_out    = s_ff.c_ph;
  assign o_decoded_binary_out = s_ff.decoded_binary_out;
  assign o_decoder_clock_out  = s_ff.dclk;

  // ==========================================================
  // checks
  property p_zero_pair;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      (ce && src_stb && !src_bit) |=> (s_ff.pair == cmi_pkg::SYM_ZERO) && s_ff.pair_v;
  endproperty
  a_zero_pair: assert property (p_zero_pair) else $error("zero not coded low-high"); // RULE_02

  property p_one_alt;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      (ce && src_stb && src_bit) |=> (s_ff.pair == {2{$past(s_ff.alt)}}) && (s_ff.alt != $past(s_ff.alt));
  endproperty
  a_one_alt: assert property (p_one_alt) else $error("ones do not alternate"); // RULE_03

  property p_zero_keeps_alt;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      (ce && src_stb && !src_bit) |=> $stable(s_ff.alt);
  endproperty
  a_zero_keeps_alt: assert property (p_zero_keeps_alt) else $error("zero disturbed alternation"); // RULE_03

  property p_sym_order;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      (ce && s_ff.sel) |=> (o_coded_line_out == $past(s_ff.sh[1])) && !s_ff.sel;
  endproperty
  a_sym_order: assert property (p_sym_order) else $error("first symbol of pair not sent first"); // RULE_04

  property p_clk_half;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      i_coder_clock_in |=> (o_coder_clock_out != $past(o_coder_clock_out));
  endproperty
  a_clk_half: assert property (p_clk_half) else $error("coder clock out not halved"); // RULE_06

  property p_ais;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      (binary_loopback_select && i_coder_clock_in && !s_ff.c_ph) |=> s_ff.in_bit && s_ff.in_stb;
  endproperty
  a_ais: assert property (p_ais) else $error("alarm pattern not sent in binary loopback"); // RULE_13

  property p_lb_clk;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      binary_loopback_select |=> (o_decoder_clock_out == $past(s_ff.c_ph));
  endproperty
  a_lb_clk: assert property (p_lb_clk) else $error("loopback clock not routed"); // RULE_11

  property p_lb_data;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      (binary_loopback_select && i_coder_clock_in) |=> (o_decoded_binary_out == $past(s_ff.lb[2]));
  endproperty
  a_lb_data: assert property (p_lb_data) else $error("loopback data not routed"); // RULE_12

  property p_dec_out;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      (!binary_loopback_select && i_decoder_clock_in) |=> (o_decoded_binary_out == $past(dec.late_bit));
  endproperty
  a_dec_out: assert property (p_dec_out) else $error("decoded output stage wrong"); // RULE_09

  property p_reset;
    @(posedge i_ref_clk)
      !i_rst_n |=> !o_coded_line_out && !o_coder_clock_out && !s_ff.alt && !o_decoded_binary_out;
  endproperty
  a_reset: assert property (p_reset) else $error("reset state wrong"); // RULE_19

endmodule

`default_nettype wire

// ---- tb/cmi_far_end.sv ----
// far-end line model: recovered clock enables and coded symbols
`timescale 1ns/10ps
`default_nettype none

module cmi_far_end #(
  parameter logic [15:0] PAT = 16'h0000
) (
  // clock
  input  wire logic i_ref_clk,
  // control
  input  wire logic i_run,
  // line side
  output logic      o_dce,
  output logic      o_sym
);
  logic [3:0] idx  = 4'h0;
  logic       half = 1'b0;
  logic       alt  = 1'b0;

  initial begin
    o_dce = 1'b0;
    o_sym = 1'b0;
  end

  // ==========================================================
  // symbol generator
  always @(posedge i_ref_clk) begin
    #1;
    if (!i_run) begin
      o_dce = 1'b0;
      o_sym = ~o_sym;  // released line, no stale level
    end else begin
      o_dce = ~o_dce;
      if (o_dce) begin
        o_sym = PAT[4'hf - idx] ? alt : half;
        if (half && PAT[4'hf - idx]) alt = ~alt;
        if (half) idx = idx + 4'h1;
        half = ~half;
      end
    end
  end
endmodule

`default_nettype wire

// ---- tb/cmi_codec_bench.sv ----
// self-checking bench for the coded-mark-inversion codec
`timescale 1ns/10ps
`default_nettype none

module cmi_codec_bench;
  localparam logic [15:0] PAT = 16'h4d2b;
  logic clk = 1'b0, rst_n = 1'b0, cen = 1'b0, cgo = 1'b0, run = 1'b0;
  logic bdata = 1'b0, bval = 1'b0, binary_loopback_select = 1'b0, coded_loopback_select = 1'b0;
  logic dce, dsym, rdy, line, cco, dec, dco, cen_q, den_q;
  logic q_line[$], q_dec[$];
  int   err_total = 0, num_checks = 0;

  always #2 clk = ~clk;

  cmi_codec cmi_codec_inst (
    .i_ref_clk(clk), .i_rst_n(rst_n), .i_coder_clock_in(cen), .i_binary_data_in(bdata),
    .i_binary_valid(bval), .o_binary_ready(rdy), .o_coded_line_out(line), .o_coder_clock_out(cco),
    .i_decoder_clock_in(dce), .i_coded_line_in(dsym), .o_decoded_binary_out(dec),
    .o_decoder_clock_out(dco), .i_binary_loopback_select(binary_loopback_select), .i_coded_loopback_select(coded_loopback_select));

  cmi_far_end #(.PAT(PAT)) cmi_far_end_inst (.i_ref_clk(clk), .i_run(run), .o_dce(dce), .o_sym(dsym));

  // ==========================================================
  // coder enables and output capture
  always @(posedge clk) begin
    #1;
    cen = cgo && !cen;
  end

  always @(posedge clk) begin
    cen_q <= cen;
    den_q <= dce;
    if (cen_q || den_q) begin
      q_line.push_back(line);
      q_dec.push_back(dec);
    end
  end

  // ==========================================================
  // helpers
  task automatic chk(input string name, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %b seen %b", name, exp, got);
    end
  endtask

  function automatic logic has_pat(logic b[$]);
    logic hit;
    for (int i = 0; i + 16 <= b.size(); i++) begin
      hit = 1'b1;
      for (int j = 0; j < 16; j++) if (b[i+j] !== PAT[15-j]) hit = 1'b0;
      if (hit) return 1'b1;
    end
    return 1'b0;
  endfunction

  task automatic dec_line(output logic b[$], output logic ok);
    logic good, seen, last;
    ok = 1'b0;
    for (int p = 0; p < 2 && !ok; p++) begin
      b = {};
      good = 1'b1;
      seen = 1'b0;
      last = 1'b0;
      for (int i = p; i + 1 < q_line.size(); i += 2) begin
        if (q_line[i] === 1'b1 && q_line[i+1] === 1'b0) good = 1'b0;
        else if (q_line[i] === q_line[i+1]) begin
          if (seen && q_line[i] === last) good = 1'b0;
          seen = 1'b1;
          last = q_line[i];
          b.push_back(1'b1);
        end else b.push_back(1'b0);
      end
      ok = good && b.size() > 8;
    end
  endtask

  task automatic chk_dec(input string name);
    logic b0[$], b1[$];
    foreach (q_dec[i]) if (i % 2) b1.push_back(q_dec[i]); else b0.push_back(q_dec[i]);
    chk(name, 1'b1, has_pat(b0) | has_pat(b1));
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic send_bit(input logic b);
    int n = 0;
    bdata = b;
    bval = 1'b1;
    while (rdy !== 1'b1 && n < 200) begin
      cycles(1);
      n++;
    end
    chk("ready", 1'b1, rdy);
    cycles(1);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset;
    rst_n = 1'b0;
    cycles(6);
    chk("ready", 1'b1, rdy);
    chk("line", 1'b0, line);
    chk("cclk", 1'b0, cco);
    chk("decoded_binary_out", 1'b0, dec);
    rst_n = 1'b1;
    cycles(2);
  endtask

  task automatic t_buffer;
    cgo = 1'b0;
    bdata = 1'b0;
    bval = 1'b1;
    cycles(4);
    chk("full", 1'b0, rdy);
    bval = 1'b0;
    cgo = 1'b1;
    cycles(12);
    chk("drained", 1'b1, rdy);
  endtask

  task automatic t_coder;
    logic b[$], ok, c0;
    cgo = 1'b1;
    cycles(20);
    q_line = {};
    for (int i = 15; i >= 0; i--) send_bit(PAT[i]);
    bval = 1'b0;
    cycles(40);
    dec_line(b, ok);
    chk("coded", 1'b1, ok);
    chk("coded data", 1'b1, has_pat(b));
    c0 = cco;
    cycles(2);
    chk("cclk toggles", ~c0, cco);
  endtask

  task automatic t_decoder;
    cgo = 1'b0;
    run = 1'b1;
    cycles(40);
    q_dec = {};
    cycles(200);
    chk_dec("decoded");
    run = 1'b0;
  endtask

  task automatic t_bin_loop;
    logic b[$], ok, c0;
    binary_loopback_select = 1'b1;
    cgo = 1'b1;
    cycles(20);
    q_line = {};
    q_dec = {};
    for (int i = 15; i >= 0; i--) send_bit(PAT[i]);
    bval = 1'b0;
    cycles(40);
    chk_dec("loop decoded_binary_out");
    dec_line(b, ok);
    chk("alarm", 1'b1, ok);
    foreach (b[i]) chk("alarm bit", 1'b1, b[i]);
    // decoder clock out is registered from the halved clock one cycle later
    for (int i = 0; i < 8; i++) begin
      c0 = cco;
      cycles(1);
      chk("loop dclk", c0, dco);
    end
    binary_loopback_select = 1'b0;
  endtask

  task automatic t_cmi_loop;
    logic b[$], ok;
    cgo = 1'b0;
    coded_loopback_select = 1'b1;
    run = 1'b1;
    cycles(40);
    q_line = {};
    cycles(200);
    dec_line(b, ok);
    chk("cmi loop", 1'b1, ok);
    chk("cmi loop data", 1'b1, has_pat(b));
    run = 1'b0;
    coded_loopback_select = 1'b0;
  endtask

  task automatic summarize;
    if (err_total == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // ==========================================================
  // main sequence and watchdog
  initial begin
    t_reset();
    t_buffer();
    t_coder();
    t_decoder();
    t_bin_loop();
    t_cmi_loop();
    t_reset();
    summarize();
  end

  initial begin
    #(20000 * 4);
    err_total++;
    summarize();
  end
endmodule

`default_nettype wire
